// file: hdl/asc_map.vh
// Register map, field positions, reset values and timing of the serial unit
`ifndef ASC_MAP_VH
`define ASC_MAP_VH
// Byte offsets
`define ASC_OFF_CTRL1 8'h00
`define ASC_OFF_CTRL2 8'h04
`define ASC_OFF_CTRL3 8'h08
`define ASC_OFF_STAT1 8'h0c
`define ASC_OFF_DATA  8'h10
// ctrl_one_reg fields
`define ASC_C1_ON    6
`define ASC_C1_CHAR9 4
`define ASC_C1_WAKE  3
`define ASC_C1_PAREN 1
`define ASC_C1_ODD   0
`define ASC_C1_WMASK 8'h5b
// ctrl_two_reg fields
`define ASC_C2_TXE_IE  7
`define ASC_C2_DONE_IE 6
`define ASC_C2_RXF_IE  5
`define ASC_C2_QUIET_IE 4
`define ASC_C2_TXEN    3
`define ASC_C2_RXON    2
`define ASC_C2_STBY    1
`define ASC_C2_BRK     0
// ctrl_three_reg fields
`define ASC_C3_RX9    7
`define ASC_C3_TX9    6
`define ASC_C3_WMASK  8'h4f
// status_one_reg fields
`define ASC_S1_TXE   7
`define ASC_S1_DONE  6
`define ASC_S1_RXF   5
`define ASC_S1_QUIET 4
`define ASC_S1_OVR   3
`define ASC_S1_NOISE 2
`define ASC_S1_FRAME 1
`define ASC_S1_PAR   0
// Reset values
`define ASC_RST_CTRL 8'h00
`define ASC_RST_STAT 8'hc0
// Timing
`define ASC_CLK_HZ  40000000
`define ASC_BAUD_HZ 9600
`define ASC_BAUD_DIV (`ASC_CLK_HZ / `ASC_BAUD_HZ)
// Bus responses
`define ASC_RESP_OK  2'b00
`define ASC_RESP_ERR 2'b10
`endif

// file: hdl/asc_tx.v
// Transmit shift register with one staged frame, shifted on the bit tick
module asc_tx (
   // Clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // Frame request
   input  wire        bit_tick,
   input  wire        load,
   input  wire [10:0] frame,
   input  wire [3:0]  len,
   // Status and line
   output wire        free,
   output wire        active,
   output reg         txd
);
   reg        staged_q;
   reg        sending_q;
   reg [10:0] fr_q;
   reg [3:0]  len_q;
   reg [10:0] sh_q;
   reg [3:0]  left_q;

   assign free   = ~staged_q;
   assign active = staged_q | sending_q;

   always @(posedge aclk) begin
      if (!aresetn) begin
         staged_q  <= 1'b0;
         sending_q <= 1'b0;
         fr_q      <= 11'h7ff;
         len_q     <= 4'h0;
         sh_q      <= 11'h7ff;
         left_q    <= 4'h0;
         txd       <= 1'b1;
      end else begin
         if (load) begin
            staged_q <= 1'b1;
            fr_q     <= frame;
            len_q    <= len;
         end
         if (bit_tick) begin
            if (left_q != 4'h0) begin
               txd    <= sh_q[0];
               sh_q   <= {1'b1, sh_q[10:1]};
               left_q <= left_q - 4'h1;
            end else if (staged_q) begin
               // Next frame follows the last bit with no gap
               txd       <= fr_q[0];
               sh_q      <= {1'b1, fr_q[10:1]};
               left_q    <= len_q - 4'h1;
               staged_q  <= 1'b0;
               sending_q <= 1'b1;
            end else begin
               txd       <= 1'b1;
               sending_q <= 1'b0;
            end
         end
      end
   end
endmodule // asc_tx

// file: hdl/asc_rx.v
// Receive shifter with three-sample majority vote and quiet-line counter
module asc_rx #(
   parameter DIV   = 4166,
   parameter CNT_W = 16
) (
   // Clock and reset
   input  wire       aclk,
   input  wire       aresetn,
   // Control
   input  wire       en,
   input  wire       char9,
   input  wire       rxd,
   // Results
   output reg        done,
   output reg  [8:0] data,
   output reg        stop_bad,
   output reg        noisy,
   output reg        quiet
);
   localparam integer     LAST_I = DIV - 1;
   localparam integer     MID_I  = DIV / 2;
   localparam [CNT_W-1:0] LAST   = LAST_I[CNT_W-1:0];
   localparam [CNT_W-1:0] MID    = MID_I[CNT_W-1:0];

   reg             busy_q;
   reg [CNT_W-1:0] cnt_q;
   reg [3:0]       idx_q;
   reg [8:0]       sh_q;
   reg             m1_q;
   reg             m2_q;
   reg [CNT_W-1:0] qcyc_q;
   reg [3:0]       qbits_q;
   wire [3:0]      ndata = char9 ? 4'd9 : 4'd8;
   wire            vote  = (m1_q & m2_q) | (m1_q & rxd) | (m2_q & rxd);
   wire            odd1  = (m1_q != m2_q) | (m2_q != rxd);

   always @(posedge aclk) begin
      if (!aresetn) begin
         busy_q <= 1'b0;
         cnt_q <= {CNT_W{1'b0}};
         idx_q <= 4'h0;
         sh_q <= 9'h000;
         m1_q <= 1'b1;
         m2_q <= 1'b1;
         qcyc_q <= {CNT_W{1'b0}};
         qbits_q <= 4'h0;
         done <= 1'b0;
         data <= 9'h000;
         stop_bad <= 1'b0;
         noisy <= 1'b0;
         quiet <= 1'b0;
      end else begin
         done  <= 1'b0;
         quiet <= 1'b0;
         if (!en) begin
            busy_q  <= 1'b0;
            qcyc_q  <= {CNT_W{1'b0}};
            qbits_q <= 4'h0;
         end else if (!busy_q) begin
            if (!rxd) begin
               busy_q  <= 1'b1;
               cnt_q   <= {CNT_W{1'b0}};
               idx_q   <= 4'h0;
               noisy   <= 1'b0;
               qcyc_q  <= {CNT_W{1'b0}};
               qbits_q <= 4'h0;
            end else if (qbits_q != ndata + 4'd2) begin
               // Count whole bit times of ones after the stop bit
               if (qcyc_q == LAST) begin
                  qcyc_q  <= {CNT_W{1'b0}};
                  qbits_q <= qbits_q + 4'h1;
                  quiet   <= (qbits_q == ndata + 4'd1);
               end else begin
                  qcyc_q <= qcyc_q + 1'b1;
               end
            end
         end else begin
            cnt_q <= (cnt_q == LAST) ? {CNT_W{1'b0}} : cnt_q + 1'b1;
            if (cnt_q == LAST)
               idx_q <= idx_q + 4'h1;
            if (cnt_q == MID - 1'b1)
               m1_q <= rxd;
            if (cnt_q == MID)
               m2_q <= rxd;
            if (cnt_q == MID + 1'b1) begin
               if (odd1)
                  noisy <= 1'b1;
               if (idx_q == 4'h0 && vote) begin
                  busy_q <= 1'b0;
               end else if (idx_q != 4'h0 && idx_q <= ndata) begin
                  sh_q <= {vote, sh_q[8:1]};
               end else if (idx_q == ndata + 4'h1) begin
                  done     <= 1'b1;
                  data     <= char9 ? sh_q : {1'b0, sh_q[8:1]};
                  stop_bad <= ~vote;
                  busy_q   <= 1'b0;
               end
            end
         end
      end
   end
endmodule // asc_rx

// file: hdl/asc_serial_unit.v
// Serial unit control, status and data registers behind an AXI4-Lite slave
`include "asc_map.vh"

module asc_serial_unit #(
   parameter BAUD_DIV = `ASC_BAUD_DIV,
   parameter CNT_W    = 16
) (
   // Clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite write
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Serial line
   input  wire        rxd,
   output wire        txd,
   // Requests
   output reg         tx_irq,
   output reg         rx_irq,
   output reg         err_irq
);
   localparam integer     TICK_LAST_I = BAUD_DIV - 1;
   localparam [CNT_W-1:0] TICK_LAST   = TICK_LAST_I[CNT_W-1:0];
   reg [7:0]       ctrl_one_q;
   reg [7:0]       ctrl_two_q;
   reg [7:0]       ctrl_three_q;
   reg [7:0]       stat_q;
   reg [7:0]       seen_q;
   reg [7:0]       tx_data_q;
   reg [7:0]       rx_data_q;
   reg             rx_ninth_bit_q;
   reg             quiet_arm_q;
   reg             rx_on_was_q;
   reg             tx_enable_was_q;
   reg             pre_pend_q;
   reg             brk_tail_q;
   reg             tx_load_q;
   reg [10:0]      tx_frame_q;
   reg [3:0]       tx_len_q;
   reg [CNT_W-1:0] baud_cnt_q;
   reg             bit_tick_q;
   reg [31:0]      rd_val;
   reg             rd_hit;
   reg             wr_hit;
   reg [7:0]       stat_d;
   reg             standby_d;
   wire module_on    = ctrl_one_q[`ASC_C1_ON];
   wire char9        = ctrl_one_q[`ASC_C1_CHAR9];
   wire tx_enable    = ctrl_two_q[`ASC_C2_TXEN];
   wire rx_on        = ctrl_two_q[`ASC_C2_RXON];
   wire rx_standby   = ctrl_two_q[`ASC_C2_STBY];
   wire send_brk     = ctrl_two_q[`ASC_C2_BRK];
   wire tx_ninth_bit = ctrl_three_q[`ASC_C3_TX9];
   wire [3:0] char_len = char9 ? 4'd11 : 4'd10;
   // Bus handshakes
   wire wr_hs   = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
   wire rd_hs   = s_axi_arready & s_axi_arvalid;
   wire wr_low  = wr_hs & s_axi_wstrb[0];
   wire rd_stat = rd_hs & (s_axi_araddr == `ASC_OFF_STAT1);
   wire rd_data = rd_hs & (s_axi_araddr == `ASC_OFF_DATA);
   wire wr_data = wr_low & (s_axi_awaddr == `ASC_OFF_DATA);
   // Transmitter and receiver
   wire       tx_free;
   wire       tx_active;
   wire       rx_done;
   wire [8:0] rx_word;
   wire       rx_stop_bad;
   wire       rx_noisy;
   wire       rx_quiet;
   asc_tx u_tx (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .bit_tick (bit_tick_q),
      .load     (tx_load_q),
      .frame    (tx_frame_q),
      .len      (tx_len_q),
      .free     (tx_free),
      .active   (tx_active),
      .txd      (txd)
   );
   asc_rx #(.DIV(BAUD_DIV), .CNT_W(CNT_W)) u_rx (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .en       (module_on & rx_on),
      .char9    (char9),
      .rxd      (rxd),
      .done     (rx_done),
      .data     (rx_word),
      .stop_bad (rx_stop_bad),
      .noisy    (rx_noisy),
      .quiet    (rx_quiet)
   );
   // Transmit choice: break, break tail, preamble, then data
   wire tx_can    = module_on & tx_enable & tx_free & ~tx_load_q;
   wire pick_brk  = tx_can & send_brk;
   wire pick_one  = tx_can & ~send_brk & brk_tail_q;
   wire pick_pre  = tx_can & ~send_brk & ~brk_tail_q & pre_pend_q;
   wire pick_data = tx_can & ~send_brk & ~brk_tail_q & ~pre_pend_q & ~stat_q[`ASC_S1_TXE];
   wire [7:0] tx_body = ctrl_one_q[`ASC_C1_PAREN] & ~char9 ?
                        {(^tx_data_q[6:0]) ^ ctrl_one_q[`ASC_C1_ODD], tx_data_q[6:0]} :
                        tx_data_q;
   wire tx_ninth = ctrl_one_q[`ASC_C1_PAREN] ?
                   (^tx_data_q) ^ ctrl_one_q[`ASC_C1_ODD] : tx_ninth_bit;
   // Received word checks
   wire [8:0] rx_bits  = char9 ? rx_word : {1'b0, rx_word[7:0]};
   wire rx_par_bad     = ctrl_one_q[`ASC_C1_PAREN] & ((^rx_bits) != ctrl_one_q[`ASC_C1_ODD]);
   wire rx_msb         = char9 ? rx_word[8] : rx_word[7];
   wire wake_mark      = ctrl_one_q[`ASC_C1_WAKE];
   wire rx_accept      = rx_done & (~rx_standby | (wake_mark & rx_msb));
   // Bit-rate enable
   always @(posedge aclk) begin
      if (!aresetn) begin
         baud_cnt_q <= {CNT_W{1'b0}};
         bit_tick_q <= 1'b0;
      end else begin
         bit_tick_q <= module_on & (baud_cnt_q == TICK_LAST);
         if (!module_on || baud_cnt_q == TICK_LAST)
            baud_cnt_q <= {CNT_W{1'b0}};
         else
            baud_cnt_q <= baud_cnt_q + 1'b1;
      end
   end
   // Transmit sequencing
   always @(posedge aclk) begin
      if (!aresetn) begin
         tx_enable_was_q <= 1'b0;
         pre_pend_q      <= 1'b0;
         brk_tail_q      <= 1'b0;
         tx_load_q       <= 1'b0;
         tx_frame_q      <= 11'h7ff;
         tx_len_q        <= 4'h0;
      end else begin
         tx_enable_was_q <= tx_enable;
         tx_load_q       <= pick_brk | pick_one | pick_pre | pick_data;
         if (!module_on)
            pre_pend_q <= 1'b0;
         else if (tx_enable & ~tx_enable_was_q)
            pre_pend_q <= 1'b1;
         else if (pick_pre | pick_brk)
            pre_pend_q <= 1'b0;
         if (pick_brk)
            brk_tail_q <= 1'b1;
         else if (pick_one)
            brk_tail_q <= 1'b0;
         if (pick_brk) begin
            tx_frame_q <= 11'h000;
            tx_len_q   <= char_len;
         end else if (pick_one) begin
            tx_frame_q <= 11'h7ff;
            tx_len_q   <= 4'd1;
         end else if (pick_pre) begin
            tx_frame_q <= 11'h7ff;
            tx_len_q   <= char_len;
         end else if (pick_data) begin
            tx_frame_q <= char9 ? {1'b1, tx_ninth, tx_body, 1'b0} :
                                  {2'b11, tx_body, 1'b0};
            tx_len_q   <= char_len;
         end
      end
   end
   // Next status: clears first, then sets, so a new event wins
   always @* begin
      stat_d    = stat_q;
      standby_d = rx_standby;
      if (rd_data) begin
         stat_d[`ASC_S1_RXF]   = stat_q[`ASC_S1_RXF] & ~seen_q[`ASC_S1_RXF];
         stat_d[`ASC_S1_QUIET] = stat_q[`ASC_S1_QUIET] & ~seen_q[`ASC_S1_QUIET];
         stat_d[`ASC_S1_OVR]   = stat_q[`ASC_S1_OVR] & ~seen_q[`ASC_S1_OVR];
         stat_d[`ASC_S1_NOISE] = stat_q[`ASC_S1_NOISE] & ~seen_q[`ASC_S1_NOISE];
         stat_d[`ASC_S1_FRAME] = stat_q[`ASC_S1_FRAME] & ~seen_q[`ASC_S1_FRAME];
         stat_d[`ASC_S1_PAR]   = stat_q[`ASC_S1_PAR] & ~seen_q[`ASC_S1_PAR];
      end
      if (wr_data && seen_q[`ASC_S1_TXE])
         stat_d[`ASC_S1_TXE] = 1'b0;
      if (pick_data)
         stat_d[`ASC_S1_TXE] = 1'b1;
      if (rx_done && rx_standby && wake_mark && rx_msb)
         standby_d = 1'b0;
      if (rx_quiet && rx_standby && !wake_mark)
         standby_d = 1'b0;
      if (rx_accept) begin
         if (stat_q[`ASC_S1_RXF]) begin
            stat_d[`ASC_S1_OVR] = 1'b1;
         end else begin
            stat_d[`ASC_S1_RXF] = 1'b1;
            if (rx_noisy)
               stat_d[`ASC_S1_NOISE] = 1'b1;
            if (rx_stop_bad)
               stat_d[`ASC_S1_FRAME] = 1'b1;
            if (rx_par_bad)
               stat_d[`ASC_S1_PAR] = 1'b1;
         end
      end
      if (rx_quiet && !rx_standby && quiet_arm_q)
         stat_d[`ASC_S1_QUIET] = 1'b1;
      stat_d[`ASC_S1_DONE] = stat_d[`ASC_S1_TXE] & ~tx_active & ~tx_load_q & ~pre_pend_q &
                             ~brk_tail_q & ~(tx_enable & send_brk);
      if (!module_on) begin
         stat_d[`ASC_S1_TXE]  = 1'b1;
         stat_d[`ASC_S1_DONE] = 1'b1;
      end
   end
   // Registers and flags
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_one_q     <= `ASC_RST_CTRL;
         ctrl_two_q     <= `ASC_RST_CTRL;
         ctrl_three_q   <= `ASC_RST_CTRL;
         stat_q         <= `ASC_RST_STAT;
         seen_q         <= 8'h00;
         tx_data_q      <= 8'h00;
         rx_data_q      <= 8'h00;
         rx_ninth_bit_q <= 1'b0;
         quiet_arm_q    <= 1'b0;
         rx_on_was_q    <= 1'b0;
      end else begin
         stat_q      <= stat_d;
         rx_on_was_q <= rx_on;
         ctrl_two_q[`ASC_C2_STBY] <= standby_d;
         if (rd_stat)
            seen_q <= stat_q;
         else if (rd_data)
            seen_q <= seen_q & 8'hc0;
         else if (wr_data)
            seen_q <= seen_q & 8'h7f;
         if (rx_accept && !stat_q[`ASC_S1_RXF]) begin
            rx_data_q      <= rx_word[7:0];
            rx_ninth_bit_q <= rx_msb;
         end
         if (rx_on & ~rx_on_was_q)
            quiet_arm_q <= 1'b0;
         else if (rx_accept && !stat_q[`ASC_S1_RXF])
            quiet_arm_q <= 1'b1;
         else if (stat_d[`ASC_S1_QUIET] ^ stat_q[`ASC_S1_QUIET])
            quiet_arm_q <= 1'b0;
         if (wr_low) begin
            case (s_axi_awaddr)
               `ASC_OFF_CTRL1: ctrl_one_q <= s_axi_wdata[7:0] & `ASC_C1_WMASK;
               `ASC_OFF_CTRL2: begin
                  ctrl_two_q[7:4] <= s_axi_wdata[7:4];
                  ctrl_two_q[`ASC_C2_BRK] <= s_axi_wdata[`ASC_C2_BRK];
                  if (!(rx_standby && !standby_d))
                     ctrl_two_q[`ASC_C2_STBY] <= s_axi_wdata[`ASC_C2_STBY];
                  if (module_on)
                     ctrl_two_q[3:2] <= s_axi_wdata[3:2];
               end
               `ASC_OFF_CTRL3: ctrl_three_q <= s_axi_wdata[7:0] & `ASC_C3_WMASK;
               `ASC_OFF_DATA:  tx_data_q <= s_axi_wdata[7:0];
               default: ;
            endcase
         end
      end
   end

   // Request outputs
   always @(posedge aclk) begin
      if (!aresetn) begin
         tx_irq  <= 1'b0;
         rx_irq  <= 1'b0;
         err_irq <= 1'b0;
      end else begin
         tx_irq  <= module_on &
                    ((ctrl_two_q[`ASC_C2_TXE_IE] & stat_q[`ASC_S1_TXE]) |
                     (ctrl_two_q[`ASC_C2_DONE_IE] & stat_q[`ASC_S1_DONE]));
         rx_irq  <= ~rx_standby &
                    ((ctrl_two_q[`ASC_C2_RXF_IE] & stat_q[`ASC_S1_RXF]) |
                     (ctrl_two_q[`ASC_C2_QUIET_IE] & stat_q[`ASC_S1_QUIET]));
         err_irq <= |(ctrl_three_q[3:0] & stat_q[3:0]);
      end
   end

   // Read data and decode
   always @* begin
      rd_hit = 1'b1;
      rd_val = 32'h0000_0000;
      case (s_axi_araddr)
         `ASC_OFF_CTRL1: rd_val = {24'h00_0000, ctrl_one_q};
         `ASC_OFF_CTRL2: rd_val = {24'h00_0000, ctrl_two_q};
         `ASC_OFF_CTRL3: rd_val = {24'h00_0000, rx_ninth_bit_q, ctrl_three_q[6:0]};
         `ASC_OFF_STAT1: rd_val = {24'h00_0000, stat_q};
         `ASC_OFF_DATA:  rd_val = {24'h00_0000, rx_data_q};
         default:        rd_hit = 1'b0;
      endcase
      case (s_axi_awaddr)
         `ASC_OFF_CTRL1, `ASC_OFF_CTRL2, `ASC_OFF_CTRL3,
         `ASC_OFF_STAT1, `ASC_OFF_DATA: wr_hit = 1'b1;
         default:                       wr_hit = 1'b0;
      endcase
   end

   // AXI4-Lite handshakes
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `ASC_RESP_OK;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= `ASC_RESP_OK;
         s_axi_rdata   <= 32'h0000_0000;
      end else begin
         if (wr_hs) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b1;
            s_axi_bresp   <= wr_hit ? `ASC_RESP_OK : `ASC_RESP_ERR;
         end else if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (rd_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_val;
            s_axi_rresp   <= rd_hit ? `ASC_RESP_OK : `ASC_RESP_ERR;
         end else if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
            s_axi_arready <= 1'b1;
         end
         if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
endmodule // asc_serial_unit

// file: verif/asc_serial_unit_checker.sv
// Bus handshake and reset-state checks for the serial unit
module asc_serial_unit_checker (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Register bus
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Line and requests
   input wire logic        txd,
   input wire logic        tx_irq,
   input wire logic        rx_irq,
   input wire logic        err_irq
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire w_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire r_hs = s_axi_arvalid && s_axi_arready;
   // Word-aligned addresses above the data buffer are unmapped
   wire w_bad = s_axi_awaddr > 8'h10 && s_axi_awaddr[1:0] == 2'b00;
   wire r_bad = s_axi_araddr > 8'h10 && s_axi_araddr[1:0] == 2'b00;
   a_wr_answer: assert property (w_hs |=> s_axi_bvalid) else $error("write unanswered");
   a_wr_unmapped: assert property (w_hs && w_bad |=> s_axi_bresp == 2'b10)
      else $error("unmapped write not refused");
   a_rd_answer: assert property (r_hs |=> s_axi_rvalid && !s_axi_arready)
      else $error("read unanswered");
   a_rd_unmapped: assert property (r_hs && r_bad |=> s_axi_rresp == 2'b10 && s_axi_rdata == 0)
      else $error("unmapped read not refused");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_ar_prompt: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_axi_arready)
      else $error("read address not taken");
   a_reset_quiet: assert property ($rose(aresetn) |-> txd && !tx_irq && !rx_irq && !err_irq)
      else $error("outputs active after reset");
   c_write: cover property (w_hs);
   c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
   c_rx_irq: cover property ($rose(rx_irq));
endmodule // asc_serial_unit_checker

bind asc_serial_unit asc_serial_unit_checker i_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready, .txd, .tx_irq, .rx_irq, .err_irq);

// file: verif/asc_node.sv
// Remote serial node: sends one 10-bit frame (start, 8 data bits, stop) per go pulse, LSB first
module asc_node #(
   parameter DIV = 8
) (
   input  wire logic       aclk,
   input  wire logic       go,
   input  wire logic [7:0] dat,
   output logic            rxd,
   output logic            busy
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [9:0] fr;
   initial begin
      rxd = 1'b1;
      busy = 1'b0;
      forever begin
         @(posedge aclk);
         if (go) begin
            busy <= 1'b1;
            fr = {1'b1, dat, 1'b0};
            for (int i = 0; i < 10; i++) begin
               rxd <= fr[i];
               repeat (DIV) @(posedge aclk);
            end
            busy <= 1'b0;
         end
      end
   end
endmodule // asc_node

// file: verif/asc_serial_unit_tb.sv
// Self-checking bench for the serial unit
module asc_serial_unit_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam DIV = 8;
   logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
   logic        awr, wrdy, bv, arr, rv, txd, rxd, tx_irq, rx_irq, err_irq, go = 0, busy;
   logic [7:0]  awaddr = 0, araddr = 0, dat = 0, b;
   logic [31:0] wdata = 0, rdata, d, seed = 32'h3756675b;
   logic [1:0]  bresp, rresp, br, rr;
   logic [10:0] fr;
   int          fail_count = 0, compares = 0, n;
   logic [7:0]  q[$];
   always #12.5 aclk = ~aclk;
   asc_serial_unit #(.BAUD_DIV(DIV)) i_asc_serial_unit (.aclk, .aresetn, .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready),
      .rxd, .txd, .tx_irq, .rx_irq, .err_irq);
   asc_node #(.DIV(DIV)) i_asc_node (.aclk, .go, .dat, .rxd, .busy);
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   task chk(input string nm, input logic [31:0] s, e);
      compares++;
      if (s !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task wr(input logic [7:0] a, v);
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, v};
      awv <= 1;
      wv <= 1;
      bready <= 1;
      do begin
         @(posedge aclk);
         if (awr)
            awv <= 0;
         if (wrdy)
            wv <= 0;
      end while (!bv);
      br = bresp;
      bready <= 0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arv <= 1;
      rready <= 1;
      do @(posedge aclk); while (!arr);
      arv <= 0;
      do @(posedge aclk); while (!rv);
      d = rdata;
      rr = rresp;
      rready <= 0;
   endtask
   task send();
      seed = xs(seed);
      q.push_back(seed[7:0]);
      @(posedge aclk);
      dat <= seed[7:0];
      go <= 1;
      @(posedge aclk);
      go <= 0;
      do @(posedge aclk); while (busy);
      repeat (2) @(posedge aclk);
   endtask
   task grab(input int nb);
      n = 0;
      while (txd) begin
         @(posedge aclk);
         n++;
      end
      repeat (DIV / 2) @(posedge aclk);
      for (int i = 0; i < nb; i++) begin
         fr[i] = txd;
         repeat (DIV) @(posedge aclk);
      end
   endtask
   task test_done();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1;
      rd(8'h0c); chk("stat_reset", d, 32'hc0);
      rd(8'h04); chk("ctrl2_reset", d, 0);
      rd(8'h14); chk("unmapped_rresp", rr, 2'b10);
      wr(8'h14, 8'hff); chk("unmapped_bresp", br, 2'b10);
      $display("test reset_map done");
      wr(8'h00, 8'h40);
      wr(8'h04, 8'h24);
      wr(8'h08, 8'h08);
      for (int i = 0; i < 3; i++) begin
         send();
         chk("rx_irq", rx_irq, 1);
         rd(8'h0c); chk("rx_full", d[5], 1);
         rd(8'h08); chk("rx_ninth", d[7], q[0][7]);
         rd(8'h10); chk("rx_data", d, q.pop_front());
         rd(8'h0c); chk("rx_clear", d[5], 0);
      end
      $display("test receive done");
      send();
      rd(8'h0c);
      send();
      rd(8'h10); chk("ovr_kept", d, q[0]);
      rd(8'h0c); chk("ovr_set", d[3], 1);
      chk("err_irq", err_irq, 1);
      rd(8'h10);
      rd(8'h0c); chk("ovr_clear", d[3], 0);
      $display("test overrun done");
      wr(8'h04, 8'h88);
      @(posedge aclk);
      chk("tx_irq_empty", tx_irq, 1);
      seed = xs(seed);
      b = seed[7:0];
      rd(8'h0c);
      wr(8'h10, b);
      grab(10);
      chk("preamble", n >= 7 * DIV, 1);
      chk("tx_frame", fr[9:0], {1'b1, b, 1'b0});
      repeat (2 * DIV) @(posedge aclk);
      rd(8'h0c); chk("tx_idle", d[7:6], 2'b11);
      wr(8'h04, 8'h48);
      @(posedge aclk);
      chk("tx_irq_done", tx_irq, 1);
      seed = xs(seed);
      b = seed[7:0];
      wr(8'h00, 8'h50);
      wr(8'h08, {1'b0, seed[8], 6'h08});
      rd(8'h0c);
      wr(8'h10, b);
      grab(11);
      chk("tx_frame9", fr, {1'b1, seed[8], b, 1'b0});
      repeat (2 * DIV) @(posedge aclk);
      wr(8'h00, 8'h00);
      @(posedge aclk);
      chk("tx_irq_off", tx_irq, 0);
      $display("test transmit done");
      test_done();
   end
   initial begin
      repeat (40000) @(posedge aclk);
      fail_count++;
      test_done();
   end
endmodule // asc_serial_unit_tb
